// ===== verilog/tx_path_pkg.sv
// Overview of operation
// - Two command words precede every buffer
// - Packet bounds come from command control bits
// - Packet tag copied into status word
// - Differing second words set error flag
// - Byte count mismatch sets error flag
// - Payload starts at offset, earlier bytes dropped
// - Each buffer applies its own offset
// - Padding up to end alignment is dropped
// - Buffers accepted in whole burst multiples
// - Completion bit raises flag once buffer loaded
// - Status word posted after every packet while status FIFO has room
// - Status words read by register reads
// - Interrupt when status count reaches threshold
// - Overfilling data FIFO sets error flag
// - Two 16-bit writes form one word
// - Command bit 31 requests completion flag
`default_nettype none
package tx_path_pkg;
  localparam logic [7:0] ADDR_TX_WORD = 8'h00;
  localparam logic [7:0] ADDR_TX_HALF = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SPACE_INFO = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam int CMD_IOC_BIT = 31;
  localparam int CMD_ALIGN_LSB = 24;
  localparam int CMD_OFFSET_LSB = 16;
  localparam int CMD_FIRST_BIT = 13;
  localparam int CMD_LAST_BIT = 12;
  localparam int LEN_W = 11;
  localparam int TAG_LSB = 16;
  localparam int FLAG_ERR_BIT = 0;
  localparam int FLAG_DONE_BIT = 1;
  localparam int CTRL_ERR_EN_BIT = 0;
  localparam int CTRL_DONE_EN_BIT = 1;
  localparam int CTRL_STAT_EN_BIT = 2;
  localparam int CTRL_THR_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_ff07;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [11:0] ALIGN_MASK_4 = 12'h003;
  localparam logic [11:0] ALIGN_MASK_16 = 12'h00f;
  localparam logic [11:0] ALIGN_MASK_32 = 12'h01f;
  localparam int DATA_FIFO_DEPTH = 16;
  localparam int STAT_FIFO_DEPTH = 8;
  typedef enum logic [1:0] {
    ST_CMD_A = 2'b00,
    ST_CMD_B = 2'b01,
    ST_DATA = 2'b10
  } parse_state_t;
endpackage
`default_nettype wire

// ===== verilog/sync_fifo.sv
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  output logic [CW-1:0] count
);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rdIdx;
  logic [AW-1:0] wrIdx;
  logic [CW-1:0] used;

  wire doPush = inValid & inReady;
  wire doPop = outValid & outReady;

  assign inReady = used != CW'(DEPTH);
  assign outValid = used != '0;
  assign outData = mem[rdIdx];
  assign count = used;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdIdx <= '0;
      wrIdx <= '0;
      used <= '0;
    end else begin
      if (doPush) wrIdx <= wrIdx + AW'(1);
      if (doPop) rdIdx <= rdIdx + AW'(1);
      used <= used + CW'(doPush) - CW'(doPop);
    end
  end

  // Storage needs no reset; the count guards it
  always_ff @(posedge clk) begin
    if (doPush) mem[wrIdx] <= inData;
  end
endmodule // sync_fifo
`default_nettype wire

// ===== verilog/halfword_pairer.sv
`default_nettype none
module halfword_pairer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic halfValid,
  input wire logic [15:0] halfData,
  output logic wordValid,
  output logic [31:0] word
);
  logic haveLow;
  logic [15:0] low;

  // Low half first, then high half
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      haveLow <= 1'b0;
      low <= 16'h0000;
      wordValid <= 1'b0;
      word <= 32'h0000_0000;
    end else begin
      wordValid <= halfValid & haveLow;
      if (halfValid) begin
        if (haveLow) word <= {halfData, low};
        else low <= halfData;
        haveLow <= ~haveLow;
      end
    end
  end
endmodule // halfword_pairer
`default_nettype wire

// ===== verilog/tx_fifo_command_datapath.sv
// Local design decisions: the register offsets and register access over APB.
`default_nettype none
module tx_fifo_command_datapath #(
  parameter int DATA_DEPTH = tx_path_pkg::DATA_FIFO_DEPTH,
  parameter int STAT_DEPTH = tx_path_pkg::STAT_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic txValid,
  output logic [31:0] txData,
  output logic [3:0] txByteEn,
  output logic txLast,
  input wire logic txReady,
  output logic irq
);
  localparam int DCW = $clog2(DATA_DEPTH + 1);
  localparam int SCW = $clog2(STAT_DEPTH + 1);
  localparam int EW = 37;

  if (DATA_DEPTH > 65535) begin : bad_data_depth
    $error("DATA_DEPTH does not fit the space field");
  end
  if (STAT_DEPTH > 255) begin : bad_stat_depth
    $error("STAT_DEPTH does not fit the count field");
  end

  function automatic logic [3:0] byteMask(input logic [11:0] base, input logic [11:0] first,
                                          input logic [11:0] stop);
    logic [3:0] m;
    logic [11:0] p;
    m = 4'h0;
    p = 12'h000;
    for (int k = 0; k < 4; k++) begin
      p = base + 12'(k);
      m[k] = (p >= first) && (p < stop);
    end
    return m;
  endfunction

  function automatic logic [2:0] byteCount(input logic [3:0] m);
    return 3'({2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]} + {2'b00, m[3]});
  endfunction

  function automatic logic [11:0] alignMask(input logic [1:0] sel);
    if (sel == tx_path_pkg::ALIGN_16) return tx_path_pkg::ALIGN_MASK_16;
    if (sel == tx_path_pkg::ALIGN_32) return tx_path_pkg::ALIGN_MASK_32;
    return tx_path_pkg::ALIGN_MASK_4;
  endfunction

  tx_path_pkg::parse_state_t state, next_state;
  logic [31:0] cmdA;
  logic [31:0] cmdB;
  logic [31:0] markerWord;
  logic [31:0] ctrl;
  logic [9:0] wordIdx;
  logic [9:0] bufWords;
  logic [11:0] pktBytes;
  logic pktErr;
  logic markerPend;
  logic errFlag;
  logic doneFlag;

  // Bus decode
  wire apbSetup = psel & ~penable;
  wire apbCommit = psel & penable & pready;
  wire hitWord = paddr == tx_path_pkg::ADDR_TX_WORD;
  wire hitHalf = paddr == tx_path_pkg::ADDR_TX_HALF;
  wire hitStatus = paddr == tx_path_pkg::ADDR_STATUS;
  wire hitSpace = paddr == tx_path_pkg::ADDR_SPACE_INFO;
  wire hitFlags = paddr == tx_path_pkg::ADDR_FLAGS;
  wire hitCtrl = paddr == tx_path_pkg::ADDR_CTRL;
  wire addrKnown = hitWord | hitHalf | hitStatus | hitSpace | hitFlags | hitCtrl;
  wire wordWrite = apbCommit & pwrite & hitWord;
  wire halfWrite = apbCommit & pwrite & hitHalf;
  wire flagWrite = apbCommit & pwrite & hitFlags;
  wire ctrlWrite = apbCommit & pwrite & hitCtrl;
  wire statPop = apbCommit & ~pwrite & hitStatus;

  // Word source: direct word write or a completed half pair
  wire pairValid;
  wire [31:0] pairWord;
  wire wordIn = wordWrite | pairValid;
  wire [31:0] wordVal = pairValid ? pairWord : pwdata;

  wire inCmdA = (state == tx_path_pkg::ST_CMD_A) & wordIn;
  wire inCmdB = (state == tx_path_pkg::ST_CMD_B) & wordIn;
  wire inData = (state == tx_path_pkg::ST_DATA) & wordIn;

  // Buffer geometry
  wire [11:0] startByte = {7'h00, cmdA[tx_path_pkg::CMD_OFFSET_LSB +: 5]};
  wire [11:0] endByte = startByte + {1'b0, cmdA[tx_path_pkg::LEN_W-1:0]};
  wire [11:0] am = alignMask(cmdA[tx_path_pkg::CMD_ALIGN_LSB +: 2]);
  wire [11:0] roundEnd = (endByte + am) & ~am;
  wire [9:0] nextWords = roundEnd[11:2];
  wire [11:0] base = {wordIdx, 2'b00};
  wire [3:0] mask = inData ? byteMask(base, startByte, endByte) : 4'h0;
  wire [11:0] bytesNow = pktBytes + {9'h000, byteCount(mask)};
  wire lastSeg = cmdA[tx_path_pkg::CMD_LAST_BIT];
  wire firstSeg = cmdA[tx_path_pkg::CMD_FIRST_BIT];
  wire lastWord = wordIdx == (bufWords - 10'h001);
  wire finish = (inCmdB & (nextWords == 10'h000)) | (inData & lastWord);
  wire pktEnd = finish & lastSeg;
  wire [31:0] cmdBNow = (state == tx_path_pkg::ST_CMD_B) ? wordVal : cmdB;

  // Later buffers must repeat the previous second word
  wire cmdBBad = inCmdB & ~firstSeg & (wordVal != cmdB);
  wire lenBad = pktEnd & (bytesNow != {1'b0, cmdBNow[tx_path_pkg::LEN_W-1:0]});

  // Zero masks are offset or padding words and never enter the FIFO
  wire dataPush = mask != 4'h0;
  wire markerPush = markerPend & ~dataPush;
  wire fifoInReady;
  wire overflow = dataPush & ~fifoInReady;
  wire pktFail = pktErr | cmdBBad | lenBad | overflow;
  wire [31:0] next_markerWord = {cmdBNow[tx_path_pkg::TAG_LSB +: 16], pktFail, 4'h0,
                                 bytesNow[tx_path_pkg::LEN_W-1:0]};
  wire [EW-1:0] fifoIn = dataPush ? {1'b0, mask, wordVal} : {1'b1, 4'h0, markerWord};
  wire errSet = overflow | cmdBBad | lenBad;
  wire doneSet = finish & cmdA[tx_path_pkg::CMD_IOC_BIT];

  // Drain side
  wire fifoOutValid;
  wire [EW-1:0] fifoOut;
  wire [DCW-1:0] dataCount;
  wire loadOut = fifoOutValid & (~txValid | txReady);
  wire statPush = txValid & txReady & txLast;
  wire statInReady;
  wire statOutValid;
  wire [31:0] statOut;
  wire [SCW-1:0] statCount;

  // Register read selection
  wire [15:0] dataFree = 16'(DATA_DEPTH) - 16'(dataCount);
  wire [7:0] statCount8 = 8'(statCount);
  wire [31:0] spaceInfo = {8'h00, statCount8, dataFree};
  wire [31:0] flagsWord = {30'h0000_0000, doneFlag, errFlag};
  wire [31:0] statRead = statOutValid ? statOut : 32'h0000_0000;
  wire [31:0] readMux = hitStatus ? statRead :
                        hitSpace ? spaceInfo :
                        hitFlags ? flagsWord :
                        hitCtrl ? (ctrl & tx_path_pkg::CTRL_MASK) : 32'h0000_0000;
  wire statReached = statCount8 >= ctrl[tx_path_pkg::CTRL_THR_LSB +: 8];
  wire next_irq = (errFlag & ctrl[tx_path_pkg::CTRL_ERR_EN_BIT]) |
                  (doneFlag & ctrl[tx_path_pkg::CTRL_DONE_EN_BIT]) |
                  (statReached & ctrl[tx_path_pkg::CTRL_STAT_EN_BIT]);

  always_comb begin
    next_state = state;
    case (state)
      tx_path_pkg::ST_CMD_A: if (wordIn) next_state = tx_path_pkg::ST_CMD_B;
      tx_path_pkg::ST_CMD_B: begin
        if (wordIn) next_state = (nextWords == 10'h000) ? tx_path_pkg::ST_CMD_A
                                                        : tx_path_pkg::ST_DATA;
      end
      tx_path_pkg::ST_DATA: if (finish) next_state = tx_path_pkg::ST_CMD_A;
      default: next_state = tx_path_pkg::ST_CMD_A;
    endcase
  end

  halfword_pairer u_pairer (
    .clk(clk),
    .rstn(rstn),
    .halfValid(halfWrite),
    .halfData(pwdata[15:0]),
    .wordValid(pairValid),
    .word(pairWord)
  );

  sync_fifo #(.WIDTH(EW), .DEPTH(DATA_DEPTH)) u_data_fifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(dataPush | markerPush),
    .inData(fifoIn),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOut),
    .outReady(loadOut),
    .count(dataCount)
  );

  // A full status FIFO drops the word; software should keep it drained
  sync_fifo #(.WIDTH(32), .DEPTH(STAT_DEPTH)) u_stat_fifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(statPush),
    .inData(txData),
    .inReady(statInReady),
    .outValid(statOutValid),
    .outData(statOut),
    .outReady(statPop),
    .count(statCount)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= tx_path_pkg::ST_CMD_A;
      cmdA <= 32'h0000_0000;
      cmdB <= 32'h0000_0000;
      bufWords <= 10'h000;
      wordIdx <= 10'h000;
    end else begin
      state <= next_state;
      if (inCmdA) cmdA <= wordVal;
      if (inCmdB) cmdB <= wordVal;
      if (inCmdB) bufWords <= nextWords;
      if (inCmdB) wordIdx <= 10'h000;
      else if (inData) wordIdx <= wordIdx + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pktBytes <= 12'h000;
      pktErr <= 1'b0;
    end else if ((inCmdA & wordVal[tx_path_pkg::CMD_FIRST_BIT]) | pktEnd) begin
      pktBytes <= 12'h000;
      pktErr <= 1'b0;
    end else begin
      if (inData) pktBytes <= bytesNow;
      pktErr <= pktErr | cmdBBad | overflow;
    end
  end

  // Marker closes the packet in the FIFO, pushed from the cycle after the packet's last buffer word, once the FIFO has room
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      markerPend <= 1'b0;
      markerWord <= 32'h0000_0000;
    end else if (pktEnd) begin
      markerPend <= 1'b1;
      markerWord <= next_markerWord;
    end else if (markerPush & fifoInReady) begin
      markerPend <= 1'b0;
    end
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      errFlag <= 1'b0;
      doneFlag <= 1'b0;
      ctrl <= tx_path_pkg::CTRL_RESET;
      irq <= 1'b0;
    end else begin
      errFlag <= errSet | (errFlag & ~(flagWrite & pwdata[tx_path_pkg::FLAG_ERR_BIT]));
      doneFlag <= doneSet | (doneFlag & ~(flagWrite & pwdata[tx_path_pkg::FLAG_DONE_BIT]));
      if (ctrlWrite) ctrl <= pwdata;
      irq <= next_irq;
    end
  end

  // Zero wait states: read data is sampled during setup
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apbSetup;
      pslverr <= apbSetup & ~addrKnown;
      if (apbSetup) prdata <= readMux;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txValid <= 1'b0;
      txData <= 32'h0000_0000;
      txByteEn <= 4'h0;
      txLast <= 1'b0;
    end else if (loadOut) begin
      txValid <= 1'b1;
      txData <= fifoOut[31:0];
      txByteEn <= fifoOut[35:32];
      txLast <= fifoOut[36];
    end else if (txReady) begin
      txValid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  packet_marker_a: assert property (pktEnd |=> markerPend && markerWord[31:16] ==
      $past(cmdBNow[31:16])) else $error("Packet end did not queue tagged marker");
  length_error_a: assert property (lenBad |=> errFlag && markerWord[15])
    else $error("Length mismatch not flagged");
  cmdb_mismatch_a: assert property (cmdBBad ##1 !pktEnd[*1] |-> errFlag)
    else $error("Second word mismatch not flagged");
  overfill_a: assert property (dataPush && !fifoInReady |=> errFlag)
    else $error("Overfill not flagged");
  done_flag_a: assert property (finish && cmdA[tx_path_pkg::CMD_IOC_BIT] |=> doneFlag)
    else $error("Completion flag not raised");
  offset_drop_a: assert property (inData && (base + 12'h003) < startByte |-> !dataPush)
    else $error("Byte before offset was kept");
  pad_drop_a: assert property (inData && base >= endByte |-> !dataPush)
    else $error("Padding word was kept");
  status_post_a: assert property (statPush && statInReady && !statPop |=>
      statCount == $past(statCount) + 1'b1) else $error("Status word not posted");
  status_read_a: assert property (apbSetup && hitStatus && statOutValid |=>
      prdata == $past(statOut)) else $error("Status read returned wrong word");
  pair_word_a: assert property (pairValid |-> $past(halfWrite))
    else $error("Word formed without a high half");
  stat_irq_a: assert property (ctrl[tx_path_pkg::CTRL_STAT_EN_BIT] && statReached ##1
      ctrl[tx_path_pkg::CTRL_STAT_EN_BIT] |-> ##[0:1] irq)
    else $error("Status threshold interrupt missing");
  err_irq_a: assert property (errFlag && ctrl[tx_path_pkg::CTRL_ERR_EN_BIT] |=> irq)
    else $error("Masked-in error did not interrupt");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("Output beat changed while stalled");

  // Bus answer checks; the slave raises pready in the first access cycle
  pready_pulse_a: assert property (apbSetup |=> pready)
    else $error("Access cycle without pready");
  unmapped_read_a: assert property (apbSetup && !addrKnown |=> pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped access not refused");
  empty_status_a: assert property (apbSetup && hitStatus && !statOutValid |=>
      prdata == 32'h0000_0000) else $error("Empty status read not zero");
  // Drain port: markers carry no lanes, data beats always carry some
  marker_lanes_a: assert property (txValid && txLast |-> txByteEn == 4'h0)
    else $error("Marker beat with byte lanes");
  data_lanes_a: assert property (txValid && !txLast |-> txByteEn != 4'h0)
    else $error("Empty data beat sent");
  tx_release_a: assert property (txValid && txReady && !fifoOutValid |=> !txValid)
    else $error("Beat repeated after acceptance");
  buffer_start_a: assert property (inCmdB |=> wordIdx == 10'h000)
    else $error("Buffer did not restart word count");
  burst_round_a: assert property (inCmdB &&
      cmdA[tx_path_pkg::CMD_ALIGN_LSB +: 2] == tx_path_pkg::ALIGN_16 |-> nextWords[1:0] == 2'b00)
    else $error("Buffer not rounded to burst");
  err_hold_a: assert property (errFlag && !flagWrite |=> errFlag)
    else $error("Error flag lost without clear");
  done_irq_a: assert property (doneFlag && ctrl[tx_path_pkg::CTRL_DONE_EN_BIT] |=> irq)
    else $error("Loaded flag did not interrupt");
endmodule // tx_fifo_command_datapath
`default_nettype wire

// ===== verif/tx_sink_model.sv
`default_nettype none
module tx_sink_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall,
  input wire logic txValid,
  input wire logic [31:0] txData,
  input wire logic [3:0] txByteEn,
  input wire logic txLast,
  output logic txReady
);
  logic [36:0] beats[$];
  // Stall on request, so the back-pressure paths get exercised
  assign txReady = ~stall;
  always @(posedge clk) begin
    if (rstn && txValid && txReady) begin
      beats.push_back({txLast, txByteEn, txData});
    end
  end
endmodule // tx_sink_model
`default_nettype wire

// ===== verif/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, txData, rdat;
  logic [3:0] txByteEn;
  logic pready, pslverr, txValid, txLast, txReady, irq, rerr;
  int mismatches = 0, nChecks = 0, base;
  always #12.5 clk = ~clk;
  tx_fifo_command_datapath u_tx_fifo_command_datapath (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txValid(txValid),
    .txData(txData), .txByteEn(txByteEn), .txLast(txLast), .txReady(txReady), .irq(irq));
  tx_sink_model u_tx_sink_model (.clk(clk), .rstn(rstn), .stall(stall),
    .txValid(txValid), .txData(txData), .txByteEn(txByteEn), .txLast(txLast),
    .txReady(txReady));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Slave latency is not assumed, only bounded; answer taken at the edge
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wd(input logic [31:0] d);
    wr(tx_path_pkg::ADDR_TX_WORD, d);
  endtask
  task automatic wh(input logic [31:0] d);
    wr(tx_path_pkg::ADDR_TX_HALF, {16'h0, d[15:0]});
    wr(tx_path_pkg::ADDR_TX_HALF, {16'h0, d[31:16]});
  endtask
  function automatic logic [31:0] ca(input logic ioc, input logic [1:0] al,
      input logic [4:0] off, input logic f, input logic l, input logic [10:0] sz);
    ca = 32'h0;
    ca[tx_path_pkg::CMD_IOC_BIT] = ioc;
    ca[tx_path_pkg::CMD_ALIGN_LSB+:2] = al;
    ca[tx_path_pkg::CMD_OFFSET_LSB+:5] = off;
    ca[tx_path_pkg::CMD_FIRST_BIT] = f;
    ca[tx_path_pkg::CMD_LAST_BIT] = l;
    ca[10:0] = sz;
  endfunction
  task automatic waitb(input int n);
    int k;
    k = 0;
    while (u_tx_sink_model.beats.size() < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    cyc(4);
  endtask
  task automatic beat(input int i, input logic [31:0] d, input logic [3:0] be,
      input logic l);
    logic [36:0] b;
    logic [31:0] m;
    b = u_tx_sink_model.beats[i];
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    if (be == 4'h0) begin
      m = 32'hffffffff;
    end
    chk("beat lanes", {27'h0, l, be}, {27'h0, b[36:32]});
    chk("beat data", d & m, b[31:0] & m);
  endtask
  task automatic pkt(input logic [15:0] tag);
    base = u_tx_sink_model.beats.size();
    wd(ca(1'b0, 2'h0, 5'd0, 1'b1, 1'b1, 11'd4));
    wd({tag, 16'h0004});
    wd(32'h0);
    waitb(base + 2);
  endtask
  task automatic s_regs();
    rd(tx_path_pkg::ADDR_CTRL);
    chk("ctrl reset", tx_path_pkg::CTRL_RESET, rdat);
    rd(tx_path_pkg::ADDR_FLAGS);
    chk("flags reset", 32'h0, rdat);
    wr(tx_path_pkg::ADDR_CTRL, 32'hffffffff);
    rd(tx_path_pkg::ADDR_CTRL);
    chk("ctrl bits", tx_path_pkg::CTRL_MASK, rdat);
    wr(tx_path_pkg::ADDR_CTRL, 32'h0);
    rd(8'h18);
    chk("unmapped", 32'h1, {31'h0, rerr});
    rd(tx_path_pkg::ADDR_STATUS);
    chk("empty status", 32'h0, rdat);
  endtask
  task automatic s_single();
    base = u_tx_sink_model.beats.size();
    rd(tx_path_pkg::ADDR_SPACE_INFO);
    chk("free", 32'(tx_path_pkg::DATA_FIFO_DEPTH), {16'h0, rdat[15:0]});
    wd(ca(1'b1, 2'h0, 5'd1, 1'b1, 1'b1, 11'd5));
    wd(32'hbeef0005);
    wd(32'h44332211);
    wd(32'h88776655);
    waitb(base + 3);
    beat(base, 32'h44332211, 4'he, 1'b0);
    beat(base + 1, 32'h88776655, 4'h3, 1'b0);
    beat(base + 2, 32'hbeef0005, 4'h0, 1'b1);
    rd(tx_path_pkg::ADDR_FLAGS);
    chk("loaded flag", 32'h2, rdat);
    rd(tx_path_pkg::ADDR_STATUS);
    chk("status word", 32'hbeef0005, rdat);
    wr(tx_path_pkg::ADDR_FLAGS, 32'h2);
    rd(tx_path_pkg::ADDR_FLAGS);
    chk("flag clear", 32'h0, rdat);
  endtask
  task automatic s_split();
    base = u_tx_sink_model.beats.size();
    @(posedge clk);
    stall <= 1'b1;
    wd(ca(1'b0, tx_path_pkg::ALIGN_16, 5'd0, 1'b1, 1'b0, 11'd6));
    wd(32'h12340008);
    wd(32'h04030201);
    wd(32'h08070605);
    wd(32'hdeadbeef);
    wd(32'hdeadbeef);
    wh(ca(1'b0, 2'h0, 5'd3, 1'b0, 1'b1, 11'd2));
    wh(32'h12340008);
    wh(32'h09aaaaaa);
    wh(32'hbbbbbb0a);
    @(posedge clk);
    stall <= 1'b0;
    waitb(base + 5);
    beat(base, 32'h04030201, 4'hf, 1'b0);
    beat(base + 1, 32'h00000605, 4'h3, 1'b0);
    beat(base + 2, 32'h09000000, 4'h8, 1'b0);
    beat(base + 3, 32'h0000000a, 4'h1, 1'b0);
    beat(base + 4, 32'h12340008, 4'h0, 1'b1);
    rd(tx_path_pkg::ADDR_FLAGS);
    chk("no flags", 32'h0, rdat);
    rd(tx_path_pkg::ADDR_STATUS);
    chk("split status", 32'h12340008, rdat);
  endtask
  task automatic s_err();
    wd(ca(1'b0, 2'h0, 5'd0, 1'b1, 1'b0, 11'd4));
    wd(32'h00010008);
    wd(32'h1);
    wd(ca(1'b0, 2'h0, 5'd0, 1'b0, 1'b1, 11'd4));
    wd(32'h00020008);
    wd(32'h2);
    cyc(6);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(tx_path_pkg::ADDR_FLAGS);
    chk("tag mismatch", 32'h1, rdat);
    wr(tx_path_pkg::ADDR_CTRL, 32'h1);
    cyc(2);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(tx_path_pkg::ADDR_FLAGS, 32'h1);
    cyc(2);
    chk("irq off", 32'h0, {31'h0, irq});
    wr(tx_path_pkg::ADDR_CTRL, 32'h0);
    rd(tx_path_pkg::ADDR_STATUS);
    chk("err status", 32'h00008008, rdat & 32'hffff);
    wd(ca(1'b0, 2'h0, 5'd0, 1'b1, 1'b1, 11'd4));
    wd(32'h00030009);
    wd(32'h3);
    cyc(8);
    rd(tx_path_pkg::ADDR_FLAGS);
    chk("length error", 32'h1, rdat);
    rd(tx_path_pkg::ADDR_STATUS);
    chk("len status", 32'h00038004, rdat);
    wr(tx_path_pkg::ADDR_FLAGS, 32'h1);
  endtask
  task automatic s_ovf();
    @(posedge clk);
    stall <= 1'b1;
    wd(ca(1'b0, 2'h0, 5'd0, 1'b1, 1'b1, 11'd80));
    wd(32'h00070050);
    for (int i = 0; i < 20; i++) begin
      wd(32'(i));
    end
    rd(tx_path_pkg::ADDR_FLAGS);
    chk("overflow", 32'h1, rdat);
    @(posedge clk);
    stall <= 1'b0;
    cyc(60);
    rd(tx_path_pkg::ADDR_STATUS);
    chk("ovf status", 32'h00008050, rdat & 32'hffff);
    wr(tx_path_pkg::ADDR_FLAGS, 32'h1);
  endtask
  task automatic s_thr();
    rd(tx_path_pkg::ADDR_SPACE_INFO);
    chk("held", 32'h0, {24'h0, rdat[23:16]});
    wr(tx_path_pkg::ADDR_CTRL, 32'h0204);
    pkt(16'h0011);
    chk("irq below", 32'h0, {31'h0, irq});
    pkt(16'h0012);
    chk("irq at thr", 32'h1, {31'h0, irq});
    rd(tx_path_pkg::ADDR_STATUS);
    chk("first tag", 32'h00110004, rdat);
    cyc(3);
    chk("irq drop", 32'h0, {31'h0, irq});
    wr(tx_path_pkg::ADDR_CTRL, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    s_regs();
    s_single();
    s_split();
    s_err();
    s_ovf();
    s_thr();
    tally_and_finish();
  end
  // Whole run is a few hundred cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
